/* tb/bcs_chk.sv */
`timescale 1ns/1ps
module bcs_chk (
   input wire logic        CLOCK,
   input wire logic        ARST_N,
   input wire logic        PWM,
   input wire logic [15:0] COMM_DELAY,
   input wire logic        DEMAG_BY_TIMER,
   input wire logic [5:0]  GATE,
   input wire logic [2:0]  STEP,
   input wire logic        ZERO_EVENT,
   input wire logic        COMM_EVENT,
   input wire logic        DEMAG_EVENT,
   input wire logic [1:0]  PHASE
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);
   property p_comm; ZERO_EVENT && COMM_DELAY == 16'h0003 |-> ##4 COMM_EVENT; endproperty
   a_comm: assert property (p_comm) else $error("comm late");
   property p_zero; ZERO_EVENT |-> $past(PHASE) == 2'h0; endproperty
   a_zero: assert property (p_zero) else $error("zero early");
   property p_tmr; COMM_EVENT && DEMAG_BY_TIMER |-> ##[1:4] DEMAG_EVENT; endproperty
   a_tmr: assert property (p_tmr) else $error("no demag");
   property p_ord; DEMAG_EVENT |-> $past(PHASE) == 2'h2 && PHASE == 2'h0; endproperty
   a_ord: assert property (p_ord) else $error("bad order");
   property p_win; ZERO_EVENT |-> !$past(PWM) && !$past(PWM, 2) && !$past(PWM, 3); endproperty
   a_win: assert property (p_win) else $error("out of window");
   property p_hi; !$past(PWM) |-> (GATE & 6'h15) == 6'h00; endproperty
   a_hi: assert property (p_hi) else $error("high side on");
   property p_step; COMM_EVENT && $past(STEP) != 3'h5 |-> STEP == $past(STEP) + 3'h1; endproperty
   a_step: assert property (p_step) else $error("bad step");
   property p_wrap; COMM_EVENT && $past(STEP) == 3'h5 |-> STEP == 3'h0; endproperty
   a_wrap: assert property (p_wrap) else $error("no wrap");
endmodule : bcs_chk

/* tb/bcs_motor.sv */
`timescale 1ns/1ps
module bcs_motor (
   input  wire logic       CLOCK,
   input  wire logic [2:0] STEP,
   input  wire logic       slow,
   output logic            PHASE_CMP
);
   logic [7:0] cnt = 8'h00;
   logic [2:0] last = 3'h0;
   logic [7:0] lag;
   assign lag = slow ? 8'h14 : 8'h04;
   // demag low, short high at demag end, then noisy crossing
   assign PHASE_CMP = (STEP == last) && ((cnt >= 8'h03 && cnt < 8'h05)
                      || (cnt >= 8'h05 + lag && cnt[0]));
   always_ff @(posedge CLOCK) begin
      last <= STEP;
      cnt  <= (STEP != last) ? 8'h00 : cnt + 8'h01;
   end
endmodule : bcs_motor

/* tb/tb_bcs_sequencer.sv */
`timescale 1ns/1ps
module tb_bcs_sequencer;
   logic        CLOCK = 1'b0;
   logic        ARST_N = 1'b0;
   logic        RUN = 1'b0;
   logic        PHASE_RISING = 1'b1;
   logic        PWM = 1'b0;
   logic        DEMAG_BY_TIMER = 1'b0;
   logic [15:0] COMM_DELAY = 16'h0003;
   logic [15:0] WINDOW_START = 16'h0002;
   logic [15:0] DEMAG_TIMEOUT = 16'h0002;
   logic        PHASE_CMP, ZERO_EVENT, COMM_EVENT, DEMAG_EVENT;
   logic [5:0]  GATE;
   logic [2:0]  STEP;
   logic [1:0]  PHASE;
   logic        slow = 1'b0;
   logic        hold = 1'b0;
   logic [3:0]  pc = 4'h0;
   logic [2:0]  exp_step = 3'h0;
   int          errors = 0;
   int          checks = 0;
   bcs_sequencer i_dut (.*);
   bcs_motor i_motor (.CLOCK(CLOCK), .STEP(STEP), .slow(slow), .PHASE_CMP(PHASE_CMP));
   initial begin
      forever #2 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK) begin
      pc  <= pc + 4'h1;
      PWM <= pc[3] | hold;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wait_ev(ref logic ev, output int k);
      k = 0;
      do begin
         @(negedge CLOCK);
         k++;
      end while (ev !== 1'b1 && k < 300);
      if (ev !== 1'b1) begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, ev, 1'b1);
      end
   endtask : wait_ev
   task automatic run_steps(input int n);
      int k;
      logic [5:0] lo;
      for (int s = 0; s < n; s++) begin
         wait_ev(ZERO_EVENT, k);
         chk({14'h0, PHASE}, 16'h0001);
         wait_ev(COMM_EVENT, k);
         chk(16'(k), COMM_DELAY + 16'h0001);
         chk({14'h0, PHASE}, 16'h0002);
         exp_step = (exp_step == 3'h5) ? 3'h0 : exp_step + 3'h1;
         chk({13'h0, STEP}, {13'h0, exp_step});
         wait_ev(DEMAG_EVENT, k);
         chk({15'h0, DEMAG_EVENT}, 16'h0001);
         lo = (exp_step == 3'h0 || exp_step == 3'h5) ? 6'h20 : (exp_step < 3'h3) ? 6'h02 : 6'h08;
         chk({10'h0, GATE & 6'h2A}, {10'h0, lo});
      end
   endtask : run_steps
   task automatic no_window();
      int k;
      hold <= 1'b1;
      repeat (3) @(negedge CLOCK);
      k = 0;
      repeat (60) begin
         @(negedge CLOCK);
         if (ZERO_EVENT === 1'b1) k++;
      end
      chk(16'(k), 16'h0000);
      hold <= 1'b0;
      run_steps(1);
   endtask : no_window
   task automatic final_report();
      if (errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (5) @(posedge CLOCK);
      ARST_N <= 1'b1;
      repeat (3) @(posedge CLOCK);
      RUN <= 1'b1;
      run_steps(7);
      @(posedge CLOCK);
      slow           <= 1'b1;
      COMM_DELAY     <= 16'h0005;
      DEMAG_BY_TIMER <= 1'b1;
      run_steps(3);
      no_window();
      final_report();
   end
   initial begin
      #20000;
      errors++;
      final_report();
   end
endmodule : tb_bcs_sequencer

bind bcs_sequencer bcs_chk i_chk (.*);

/* verilog/bcs_pkg.sv */
package bcs_pkg;
   localparam int unsigned CLOCK_HZ      = 250_000_000;
   localparam int unsigned STEP_COUNT    = 6;
   localparam logic [2:0]  STEP_FIRST    = 3'h0;
   localparam logic [2:0]  STEP_LAST     = 3'h5;
   localparam logic [5:0]  DRIVE_RESET   = 6'h00;
   localparam logic [15:0] DELAY_RESET   = 16'h0000;
   localparam logic [15:0] WINDOW_RESET  = 16'h0000;
   localparam logic [1:0]  SYNC_RESET    = 2'h0;

   typedef enum logic [1:0] {
      BCS_WAIT_ZERO,
      BCS_WAIT_DELAY,
      BCS_WAIT_DEMAG
   } bcs_phase_t;

   // switch order per bit: t0..t5, even bits high side, odd bits low side
   function automatic logic [5:0] bcs_step_drive(input logic [2:0] step);
      case (step)
         3'h0:    bcs_step_drive = 6'b10_0001;
         3'h1:    bcs_step_drive = 6'b00_0011;
         3'h2:    bcs_step_drive = 6'b00_0110;
         3'h3:    bcs_step_drive = 6'b00_1100;
         3'h4:    bcs_step_drive = 6'b01_1000;
         3'h5:    bcs_step_drive = 6'b11_0000;
         default: bcs_step_drive = 6'b00_0000;
      endcase
   endfunction : bcs_step_drive
endpackage : bcs_pkg

/* verilog/bcs_sequencer.sv */
`timescale 1ns/1ps
// Operation
// - commutation raised itself after computed delay
// - ignore phase until demagnetisation end
// - demag end from phase or timer
// - order: zero-crossing, commutation, demag end
// - sample zero-crossing only in off-window
// - pwm applied to high-side switches only
// - commutations step through six configurations
module bcs_sequencer #(
   parameter int unsigned DW = 16
) (
   input  wire logic          CLOCK,
   input  wire logic          ARST_N,
   input  wire logic          RUN,
   input  wire logic          PHASE_CMP,
   input  wire logic          PHASE_RISING,
   input  wire logic          PWM,
   input  wire logic [DW-1:0] COMM_DELAY,
   input  wire logic [DW-1:0] WINDOW_START,
   input  wire logic          DEMAG_BY_TIMER,
   input  wire logic [DW-1:0] DEMAG_TIMEOUT,
   output logic      [5:0]    GATE,
   output logic      [2:0]    STEP,
   output logic               ZERO_EVENT,
   output logic               COMM_EVENT,
   output logic               DEMAG_EVENT,
   output logic [1:0]         PHASE
);
   typedef struct packed {
      bcs_pkg::bcs_phase_t  phase;
      logic [DW-1:0]        timer;
      logic [DW-1:0]        off_time;
      logic                 cmp_prev;
      logic [5:0]           gate;
      logic                 zero_ev;
      logic                 comm_ev;
      logic                 demag_ev;
   } bcs_state_t;

   bcs_state_t    r;
   bcs_state_t    next_r;
   logic          rst_n;
   logic [1:0]    rst_sync;
   logic          in_window;
   logic          zero_hit;
   logic          demag_hit;
   logic [5:0]    base;
   bcs_step_if    st ();

   // reset release through two flops
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_sync <= bcs_pkg::SYNC_RESET;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   bcs_step_counter u_step (
      .clk   (CLOCK),
      .rst_n (rst_n),
      .st    (st)
   );

   always_comb begin
      base = bcs_pkg::bcs_step_drive(st.step);
      // window: high side off long enough for ringing to settle
      in_window = !PWM && (r.off_time >= WINDOW_START);
      zero_hit  = in_window && (PHASE_CMP != r.cmp_prev) && (PHASE_CMP == PHASE_RISING);
      // demag ends when phase leaves the rail, or instead on timeout when DEMAG_BY_TIMER is set
      demag_hit = DEMAG_BY_TIMER ? (r.timer >= DEMAG_TIMEOUT)
                                 : (PHASE_CMP == PHASE_RISING);
   end

   always_comb begin
      next_r          = r;
      next_r.zero_ev  = 1'b0;
      next_r.comm_ev  = 1'b0;
      next_r.demag_ev = 1'b0;
      st.advance      = 1'b0;
      next_r.off_time = PWM ? '0 : ((&r.off_time) ? r.off_time : r.off_time + 1'b1);
      next_r.cmp_prev = PHASE_CMP;
      next_r.timer    = (&r.timer) ? r.timer : r.timer + 1'b1;
      if (!RUN) begin
         next_r.phase = bcs_pkg::BCS_WAIT_ZERO;
         next_r.timer = '0;
      end else begin
         case (r.phase)
            bcs_pkg::BCS_WAIT_ZERO: begin
               if (zero_hit) begin
                  next_r.zero_ev = 1'b1;
                  next_r.timer   = '0;
                  next_r.phase   = bcs_pkg::BCS_WAIT_DELAY;
               end
            end
            bcs_pkg::BCS_WAIT_DELAY: begin
               if (r.timer >= COMM_DELAY) begin
                  next_r.comm_ev = 1'b1;
                  st.advance     = 1'b1;
                  next_r.timer   = '0;
                  next_r.phase   = bcs_pkg::BCS_WAIT_DEMAG;
               end
            end
            bcs_pkg::BCS_WAIT_DEMAG: begin
               // phase input not trusted for zero-crossing here
               if (demag_hit) begin
                  next_r.demag_ev = 1'b1;
                  next_r.phase    = bcs_pkg::BCS_WAIT_ZERO;
               end
            end
            default: begin
               next_r.phase = bcs_pkg::BCS_WAIT_ZERO;
            end
         endcase
      end
      // chop only the high-side (even) switches
      next_r.gate = RUN ? (base & {3{1'b1, PWM}}) : bcs_pkg::DRIVE_RESET;
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         r.phase    <= bcs_pkg::BCS_WAIT_ZERO;
         r.timer    <= bcs_pkg::DELAY_RESET;
         r.off_time <= bcs_pkg::WINDOW_RESET;
         r.cmp_prev <= 1'b0;
         r.gate     <= bcs_pkg::DRIVE_RESET;
         r.zero_ev  <= 1'b0;
         r.comm_ev  <= 1'b0;
         r.demag_ev <= 1'b0;
      end else begin
         r.phase    <= next_r.phase;
         r.timer    <= next_r.timer;
         r.off_time <= next_r.off_time;
         r.cmp_prev <= next_r.cmp_prev;
         r.gate     <= next_r.gate;
         r.zero_ev  <= next_r.zero_ev;
         r.comm_ev  <= next_r.comm_ev;
         r.demag_ev <= next_r.demag_ev;
      end
   end

   assign GATE        = r.gate;
   assign STEP        = st.step;
   assign ZERO_EVENT  = r.zero_ev;
   assign COMM_EVENT  = r.comm_ev;
   assign DEMAG_EVENT = r.demag_ev;
   assign PHASE       = 2'(r.phase);
endmodule : bcs_sequencer

/* verilog/bcs_step_counter.sv */
`timescale 1ns/1ps
module bcs_step_counter (
   input  wire logic clk,
   input  wire logic rst_n,
   bcs_step_if.drv   st
);
   typedef struct packed {
      logic [2:0] step;
   } bcs_cnt_state_t;

   bcs_cnt_state_t r;
   bcs_cnt_state_t next_r;

   always_comb begin
      next_r = r;
      if (st.advance) begin
         if (r.step == bcs_pkg::STEP_LAST) begin
            next_r.step = bcs_pkg::STEP_FIRST;
         end else begin
            next_r.step = r.step + 3'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r.step <= bcs_pkg::STEP_FIRST;
      end else begin
         r <= next_r;
      end
   end

   assign st.step = r.step;
endmodule : bcs_step_counter

/* verilog/bcs_step_if.sv */
`timescale 1ns/1ps
interface bcs_step_if;
   logic       advance;
   logic [2:0] step;
   modport seq (output advance, input step);
   modport drv (input advance, output step);
endinterface : bcs_step_if
